// ### design/sipdc_ctrl.sv
// Stop/idle power-down sequencer of an 8-bit microcontroller core.
// Assumes the CPU reports each executed opcode with a one-cycle strobe
// and that clk is the reference the oscillator gate derives from.
//
// Design decisions made here: the strobed register port and the register addresses.
`include "sipdc_defs.svh"

// What this block does
// [R1] Stop opcode halts CPU and peripherals and stops the main oscillator.
// [R2] Register contents are held unchanged while stopped.
// [R3] Stop ends only through reset or a qualifying interrupt.
// [R4] Reset releases stop, control registers default, data kept.
// [R5] Any reset clears the clock divider field to divide-by-sixteen.
// [R6] Reset wake waits the stabilization interval, then fetches at 0100H.
// [R7] Filtered port-0 external interrupt pins can wake from stop.
// [R8] Interrupt exit from stop changes only the stop key register.
// [R9] Stabilization length is programmable; software sets it before stop.
// [R10] Interrupt exit from stop keeps the clock divider selection.
// [R11] Interrupt wake is serviced first, then execution resumes after.
// [R12] Enabled internal interrupts end stop like external ones.
// [R13] Software writes the key just before stop and follows with NOPs.
// [R14] Oscillator input is clamped to ground while stopped.
// [R15] Idle opcode gates only the CPU clock; peripherals keep running.
// [R16] Port pin directions hold as they were when idle began.
// [R17] Reset during idle defaults controls and selects divide-by-sixteen.
// [R18] With all interrupts masked only reset releases idle.
// [R19] Enabled interrupt releases idle and keeps the divider selection.
// [R20] Stop opcode without the key in place has no effect.
// [R21] Wake request is combinational from enabled pending sources.
module sipdc_ctrl (
   input wire logic clk,                 // Main reference clock
   input wire logic nrst,                // Synchronous reset, active low
   input wire logic [7:0] regAddr,       // Register address
   input wire logic [7:0] regWdata,      // Register write data
   input wire logic regWr,               // Register write strobe
   input wire logic regRd,               // Register read strobe
   output logic [7:0] regRdata,          // Read data, cycle after strobe
   input wire logic opValid,             // CPU executed an opcode
   input wire logic [7:0] opCode,        // That opcode
   input wire logic [7:0] port0ExtIrq,   // Port-0 interrupt pins
   input wire logic [7:0] intIrq,        // Internal interrupt requests
   output logic wakeReq,                 // Combinational wake request
   output logic oscEnable,               // Main oscillator runs
   output logic xinClamp,                // Oscillator input tied to ground
   output logic cpuClkEn,                // CPU clock gate
   output logic periphClkEn,             // Peripheral clock gate
   output logic portDirHold,             // Freeze port directions
   output logic [1:0] clkDivSel,         // Clock divider selection
   output logic fetchStart,              // Pulse: fetch at reset vector
   output logic [15:0] fetchVector,      // Reset vector address
   output logic irqServe                 // Pulse: service wake interrupt
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sipdc_pkg::sipdc_state_type st;
   logic [7:0] stopKey;
   logic [1:0] clkDiv;
   logic [7:0] stab;
   logic [7:0] intEn;
   logic [7:0] p0Ien;
   logic [7:0] p0Pend;
   logic [7:0] p0S1, p0S2, p0S3, p0Flt;
   logic [7:0] p0Chg;
   logic [15:0] warmCnt;
   logic fromRst;
   logic stopCmd, idleCmd, warmDone;
   logic wrKey, wrPnd;
   logic [7:0] p0Hit;
   logic [10:0] sinceRst;
   logic [15:0] rstWarmLen;

   // Warm-up length in cycles is (stab + 1) ticks
   function automatic logic [15:0] stabCycles(input logic [7:0] sel);
      logic [15:0] n;
      n = 16'({8'h00, sel} + 16'h0001) * 16'(`SIPDC_STAB_TICK_CYC);
      return n - 16'h0001;
   endfunction

   // ----------------------------------------------------------------
   // Port-0 pin filter and wake request
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      p0S1 <= port0ExtIrq;
      p0S2 <= p0S1;
      p0S3 <= p0S2;
   end

   // A level change counts only once the last two stages agree
   assign p0Chg = ~(p0S2 ^ p0S3) & (p0Flt ^ p0S3);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         p0Flt <= `SIPDC_BYTE_RST;
      end else begin
         p0Flt <= p0Flt ^ p0Chg;
      end
   end

   // No clock is assumed here so the oscillator can restart from it
   assign wakeReq = |(p0Pend & p0Ien) | |(intIrq & intEn); // [R21] [R7] [R12]

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign stopCmd = opValid && opCode == `SIPDC_OP_STOP
      && stopKey == `SIPDC_KEY_VALUE; // [R20]
   assign idleCmd = opValid && opCode == `SIPDC_OP_IDLE;
   assign warmDone = st == sipdc_pkg::SIPDC_WARM && warmCnt == 16'h0000;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         // Any reset ends in a full warm-up before the vector fetch
         st <= sipdc_pkg::SIPDC_WARM; // [R4] [R17] [R3]
         fromRst <= 1'b1;
         warmCnt <= stabCycles(`SIPDC_STAB_RST);
      end else begin
         unique case (st)
            sipdc_pkg::SIPDC_RUN: begin
               if (stopCmd) begin
                  st <= sipdc_pkg::SIPDC_STOP; // [R1]
               end else if (idleCmd) begin
                  st <= sipdc_pkg::SIPDC_IDLE; // [R15]
               end
            end
            sipdc_pkg::SIPDC_IDLE: begin
               // Masked sources never raise wakeReq
               if (wakeReq) begin
                  st <= sipdc_pkg::SIPDC_RUN; // [R19] [R18]
               end
            end
            sipdc_pkg::SIPDC_STOP: begin
               if (wakeReq) begin
                  st <= sipdc_pkg::SIPDC_WARM; // [R3] [R12]
                  fromRst <= 1'b0;
                  warmCnt <= stabCycles(stab); // [R9]
               end
            end
            sipdc_pkg::SIPDC_WARM: begin
               if (warmCnt == 16'h0000) begin
                  st <= sipdc_pkg::SIPDC_RUN; // [R6]
               end else begin
                  warmCnt <= warmCnt - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fetchStart <= 1'b0;
         irqServe <= 1'b0;
      end else begin
         fetchStart <= warmDone && fromRst; // [R6]
         // CPU takes the vector, and its return resumes after the opcode
         irqServe <= (warmDone && !fromRst)
            || (st == sipdc_pkg::SIPDC_IDLE && wakeReq); // [R11]
      end
   end

   assign fetchVector = `SIPDC_RESET_VECTOR; // [R6]
   assign oscEnable = st != sipdc_pkg::SIPDC_STOP; // [R1]
   assign xinClamp = st == sipdc_pkg::SIPDC_STOP; // [R14]
   assign cpuClkEn = st == sipdc_pkg::SIPDC_RUN; // [R15] [R1]
   assign periphClkEn = st != sipdc_pkg::SIPDC_STOP; // [R15]
   assign portDirHold = st != sipdc_pkg::SIPDC_RUN; // [R16]
   assign clkDivSel = clkDiv;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Writes land only while the CPU runs, so no write moves a register when stopped
   assign wrKey = regWr && cpuClkEn && regAddr == `SIPDC_OFS_STOP_KEY;
   assign wrPnd = regWr && cpuClkEn && regAddr == `SIPDC_OFS_P0PND;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stopKey <= `SIPDC_KEY_RST;
      end else if (st == sipdc_pkg::SIPDC_STOP && wakeReq) begin
         stopKey <= `SIPDC_KEY_RST; // [R8]
      end else if (wrKey) begin
         stopKey <= regWdata; // [R13]
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         clkDiv <= `SIPDC_DIV_RST; // [R5] [R17]
      end else if (regWr && cpuClkEn && regAddr == `SIPDC_OFS_CLKDIV) begin
         // Wake paths never touch it, so the old clock resumes
         clkDiv <= regWdata[`SIPDC_DIV_MSB:`SIPDC_DIV_LSB]; // [R10] [R19]
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stab <= `SIPDC_STAB_RST;
         intEn <= `SIPDC_BYTE_RST;
         p0Ien <= `SIPDC_BYTE_RST;
      end else if (regWr && cpuClkEn) begin
         if (regAddr == `SIPDC_OFS_STAB) begin
            stab <= regWdata; // [R9]
         end
         if (regAddr == `SIPDC_OFS_INTEN) begin
            intEn <= regWdata;
         end
         if (regAddr == `SIPDC_OFS_P0IEN) begin
            p0Ien <= regWdata;
         end
      end
   end

   // Only enabled pins can latch a request
   assign p0Hit = p0Chg & p0Ien;

   // Write 0 clears a pending bit; a same-cycle edge wins over the clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         p0Pend <= `SIPDC_BYTE_RST;
      end else begin
         p0Pend <= ((wrPnd ? (p0Pend & regWdata) : p0Pend)
            | p0Hit); // [R7] [R2]
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         regRdata <= `SIPDC_BYTE_RST;
      end else if (regRd) begin
         unique case (regAddr)
            `SIPDC_OFS_STOP_KEY: regRdata <= stopKey;
            `SIPDC_OFS_CLKDIV: regRdata <= {3'h0, clkDiv, 3'h0};
            `SIPDC_OFS_STAB: regRdata <= stab;
            `SIPDC_OFS_INTEN: regRdata <= intEn;
            `SIPDC_OFS_STATUS: regRdata <= {5'h00, fromRst, st};
            `SIPDC_OFS_P0IEN: regRdata <= p0Ien;
            `SIPDC_OFS_P0PND: regRdata <= p0Pend;
            default: regRdata <= `SIPDC_BYTE_RST;
         endcase
      end else begin
         regRdata <= `SIPDC_BYTE_RST;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Cycles since reset release, saturating, so the long reset
   // warm-up is checked against a count instead of a long delay
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sinceRst <= 11'h000;
      end else if (sinceRst != 11'h7FF) begin
         sinceRst <= sinceRst + 11'h001;
      end
   end

   assign rstWarmLen = stabCycles(`SIPDC_STAB_RST) + 16'h0001;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_stop_enter;
      st == sipdc_pkg::SIPDC_RUN && stopCmd;
   endsequence

   sequence s_int_wake;
      st == sipdc_pkg::SIPDC_STOP && wakeReq;
   endsequence

   a_stop_halts_osc: assert property ( // [R1]
      s_stop_enter |=> !oscEnable && !cpuClkEn && !periphClkEn && xinClamp)
      else $error("stop did not halt clocks");

   a_stop_holds_regs: assert property ( // [R2]
      st == sipdc_pkg::SIPDC_STOP && !wakeReq |=> $stable(clkDiv)
      && $stable(stab) && $stable(p0Ien) && $stable(stopKey))
      else $error("register changed during stop");

   a_stop_exit_cause: assert property ( // [R3]
      st == sipdc_pkg::SIPDC_STOP && !wakeReq
      |=> st == sipdc_pkg::SIPDC_STOP)
      else $error("stop left without cause");

   a_reset_div_clear: assert property ( // [R5]
      $rose(nrst) |-> clkDivSel == 2'h0 && stopKey == 8'h00)
      else $error("reset did not clear controls");

   a_reset_fetch: assert property ( // [R6]
      fetchStart == ({5'h00, sinceRst} == rstWarmLen)
      && fetchVector == `SIPDC_RESET_VECTOR)
      else $error("reset vector fetch mistimed");

   a_int_wake_key: assert property ( // [R8]
      s_int_wake |=> stopKey == 8'h00 && $stable(clkDiv)
      && $stable(intEn))
      else $error("interrupt exit changed controls");

   a_int_wake_warm: assert property ( // [R9]
      (s_int_wake and stab == 8'h00) |=> !cpuClkEn [*8] ##249 irqServe)
      else $error("stabilization length wrong");

   a_idle_gating: assert property ( // [R15]
      st == sipdc_pkg::SIPDC_RUN && idleCmd && !stopCmd
      |=> !cpuClkEn && periphClkEn && oscEnable && portDirHold)
      else $error("idle gating wrong");

   a_idle_masked: assert property ( // [R18]
      st == sipdc_pkg::SIPDC_IDLE && intEn == 8'h00 && p0Ien == 8'h00
      |=> st == sipdc_pkg::SIPDC_IDLE)
      else $error("masked source released idle");

   a_idle_wake: assert property ( // [R19]
      st == sipdc_pkg::SIPDC_IDLE && wakeReq
      |=> cpuClkEn && irqServe && $stable(clkDivSel))
      else $error("idle wake wrong");

   a_no_key_stop: assert property ( // [R20]
      st == sipdc_pkg::SIPDC_RUN && opValid
      && opCode == `SIPDC_OP_STOP && stopKey != `SIPDC_KEY_VALUE
      |=> oscEnable)
      else $error("stop taken without key");

   a_wake_comb: assert property ( // [R21]
      wakeReq == (|(p0Pend & p0Ien) || |(intIrq & intEn)))
      else $error("wake request mismatch");

   sequence s_pin_in_stop;
      st == sipdc_pkg::SIPDC_STOP && (p0Pend & p0Ien) != 8'h00;
   endsequence

   sequence s_irq_in_stop;
      st == sipdc_pkg::SIPDC_STOP && (intIrq & intEn) != 8'h00;
   endsequence

   a_reset_defaults: assert property ( // [R4] [R17]
      $rose(nrst) |-> st == sipdc_pkg::SIPDC_WARM && fromRst && !cpuClkEn
      && stab == `SIPDC_STAB_RST && intEn == `SIPDC_BYTE_RST
      && p0Ien == `SIPDC_BYTE_RST)
      else $error("reset left controls set");

   a_pin_pend_set: assert property ( // [R7]
      p0Hit != 8'h00 |=> (p0Pend & $past(p0Hit)) == $past(p0Hit))
      else $error("pin edge not latched");

   a_pin_wake_stop: assert property ( // [R7]
      s_pin_in_stop |=> st == sipdc_pkg::SIPDC_WARM && !fromRst)
      else $error("pin request did not end stop");

   a_irq_wake_stop: assert property ( // [R12]
      s_irq_in_stop |=> st == sipdc_pkg::SIPDC_WARM && !fromRst)
      else $error("internal request did not end stop");

   a_stop_div_keep: assert property ( // [R10]
      st != sipdc_pkg::SIPDC_RUN |=> $stable(clkDivSel))
      else $error("divider moved while halted");

   a_warm_serve: assert property ( // [R11]
      warmDone && !fromRst |=> irqServe && cpuClkEn && !fetchStart)
      else $error("wake service missing");

   a_serve_pulse: assert property ( // [R11]
      irqServe |=> !irqServe)
      else $error("service pulse too long");

   a_fetch_pulse: assert property ( // [R6]
      fetchStart |=> !fetchStart)
      else $error("fetch pulse too long");

   a_clamp_stop: assert property ( // [R14]
      xinClamp |-> !oscEnable && !periphClkEn && !cpuClkEn)
      else $error("clamp outside stop");

   a_dir_hold: assert property ( // [R16]
      !cpuClkEn |-> portDirHold)
      else $error("port directions not held");

endmodule

// ### design/sipdc_defs.svh
// Offsets, field positions, reset values and timing counts of the
// power-down sequencer. Assumes an 8-bit register port.
`ifndef SIPDC_DEFS_SVH
`define SIPDC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SIPDC_OFS_STOP_KEY 8'hFB
`define SIPDC_OFS_CLKDIV 8'hD4
`define SIPDC_OFS_STAB 8'hD5
`define SIPDC_OFS_INTEN 8'hD6
`define SIPDC_OFS_STATUS 8'hD7
`define SIPDC_OFS_P0IEN 8'hE2
`define SIPDC_OFS_P0PND 8'hE4

// ----------------------------------------------------------------
// Fields, codes and reset values
// ----------------------------------------------------------------
`define SIPDC_DIV_LSB 3
`define SIPDC_DIV_MSB 4
`define SIPDC_DIV_RST 2'h0
`define SIPDC_KEY_RST 8'h00
`define SIPDC_KEY_VALUE 8'hA5
`define SIPDC_OP_STOP 8'h7F
`define SIPDC_OP_IDLE 8'h6F
`define SIPDC_RESET_VECTOR 16'h0100
`define SIPDC_STAB_RST 8'h03
`define SIPDC_BYTE_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SIPDC_CLK_NS 20
`define SIPDC_STAB_TICK_NS 5120
`define SIPDC_STAB_TICK_CYC (`SIPDC_STAB_TICK_NS / `SIPDC_CLK_NS)

`endif

// ### design/sipdc_pkg.sv
// Types shared by the power-down sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sipdc_pkg;

   typedef enum logic [1:0] {
      SIPDC_RUN,
      SIPDC_IDLE,
      SIPDC_STOP,
      SIPDC_WARM
   } sipdc_state_type;

endpackage

// ### sim/sipdc_cpu_model.sv
// CPU core stand-in: executes power-down opcodes on request.
// Assumes the sequencer's clock and its CPU clock gate.
`include "sipdc_defs.svh"
module sipdc_cpu_model #(
   parameter logic [7:0] NOP_CODE = 8'h00 // No-operation opcode
) (
   input wire logic clk,            // Core clock
   input wire logic cpuClkEn,       // CPU clock gate
   input wire logic opReq,          // Bench asks for an opcode
   input wire logic [7:0] reqCode,  // Requested opcode
   output logic opValid,            // Opcode executed
   output logic [7:0] opCode        // Executed opcode
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Execution
   // ------------------------------------------------------------
   logic [1:0] nopLeft;
   initial begin
      opValid = 1'b0;
      opCode = 8'h00;
      nopLeft = 2'h0;
   end
   // A halted core executes nothing; the idle bus keeps changing
   always @(posedge clk) begin
      opValid <= 1'b0;
      opCode <= ~opCode;
      if (cpuClkEn && opReq) begin
         opValid <= 1'b1;
         opCode <= reqCode;
         if (reqCode == `SIPDC_OP_STOP) begin
            nopLeft <= 2'h3;
         end
      end else if (cpuClkEn && nopLeft != 2'h0) begin
         opValid <= 1'b1;
         opCode <= NOP_CODE;
         nopLeft <= nopLeft - 2'h1;
      end
   end
endmodule

// ### sim/tb_top.sv
// Self-checking bench of the power-down sequencer.
// Assumes the sequencer, its defines and the CPU stand-in.
`include "sipdc_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] port0ExtIrq = 8'h00;
   logic [7:0] intIrq = 8'h00;
   logic opReq = 1'b0;
   logic [7:0] reqCode = 8'h00;
   logic [7:0] regRdata, opCode;
   logic opValid, wakeReq, oscEnable, xinClamp, cpuClkEn;
   logic periphClkEn, portDirHold, fetchStart, irqServe;
   logic [1:0] clkDivSel;
   logic [15:0] fetchVector;
   int failures = 0;
   int tests_run = 0;
   sipdc_ctrl dut_u (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .opValid, .opCode, .port0ExtIrq, .intIrq, .wakeReq,
      .oscEnable, .xinClamp, .cpuClkEn, .periphClkEn, .portDirHold,
      .clkDivSel, .fetchStart, .fetchVector, .irqServe);
   sipdc_cpu_model cpu_u (.clk, .cpuClkEn, .opReq, .reqCode, .opValid,
      .opCode);
   initial begin
      forever #10 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic chkn(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         failures++;
         $display("ERROR t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk8(regRdata & m, e);
   endtask
   task automatic op(input logic [7:0] c);
      @(posedge clk);
      opReq <= 1'b1;
      reqCode <= c;
      @(posedge clk);
      opReq <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic reset_run();
      int n;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk1(cpuClkEn, 1'b0);
      chk8({6'h0, clkDivSel}, 8'h00);
      @(posedge clk);
      nrst <= 1'b1;
      n = 0;
      while (fetchStart !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      chkn(n, 1024);
      chk8(fetchVector[15:8], 8'h01);
      chk8(fetchVector[7:0], 8'h00);
      chk1(cpuClkEn, 1'b1);
      @(posedge clk);
      #1 chk1(fetchStart, 1'b0);
   endtask
   // Stabilization 0 gives a warm-up of 256 cycles before service
   task automatic stop_wake();
      int n;
      n = 0;
      while (oscEnable !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk1(oscEnable, 1'b1);
      n = 0;
      while (irqServe !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1 n++;
      end
      chkn(n, 256);
      chk1(cpuClkEn, 1'b1);
      chk8({6'h0, clkDivSel}, 8'h03);
      chk1(xinClamp, 1'b0);
      chk1(portDirHold, 1'b0);
      @(posedge clk);
      #1 chk1(irqServe, 1'b0);
   endtask
   task automatic finish_test();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      reset_run();
      rdchk(8'hFB, 8'hFF, 8'h00);
      rdchk(8'hD5, 8'hFF, 8'h03);
      wr(8'hD4, 8'h18);
      wr(8'hD5, 8'h00);
      wr(8'hE2, 8'h01);
      wr(8'hD6, 8'h04);
      rdchk(8'h10, 8'hFF, 8'h00);
      op(`SIPDC_OP_STOP);
      chk1(cpuClkEn, 1'b1);
      wr(8'hFB, `SIPDC_KEY_VALUE);
      op(`SIPDC_OP_STOP);
      chk1(oscEnable, 1'b0);
      chk1(periphClkEn, 1'b0);
      chk1(cpuClkEn, 1'b0);
      chk1(xinClamp, 1'b1);
      @(posedge clk);
      port0ExtIrq <= 8'h80;
      intIrq <= 8'h01;
      repeat (20) @(posedge clk);
      #1 chk1(oscEnable, 1'b0);
      chk8({6'h0, clkDivSel}, 8'h03);
      rdchk(8'hD7, 8'h03, 8'h02);
      @(posedge clk);
      port0ExtIrq <= 8'h81;
      stop_wake();
      rdchk(8'hFB, 8'hFF, 8'h00);
      rdchk(8'hD5, 8'hFF, 8'h00);
      rdchk(8'hE2, 8'hFF, 8'h01);
      rdchk(8'hD4, 8'hFF, 8'h18);
      wr(8'hE4, 8'h00);
      wr(8'hFB, `SIPDC_KEY_VALUE);
      op(`SIPDC_OP_STOP);
      @(posedge clk);
      intIrq <= 8'h05;
      #1 chk1(wakeReq, 1'b1);
      stop_wake();
      intIrq <= 8'h00;
      op(`SIPDC_OP_IDLE);
      chk1(cpuClkEn, 1'b0);
      chk1(periphClkEn, 1'b1);
      chk1(oscEnable, 1'b1);
      chk1(portDirHold, 1'b1);
      @(posedge clk);
      intIrq <= 8'h04;
      @(posedge clk);
      #1 chk1(irqServe, 1'b1);
      chk1(cpuClkEn, 1'b1);
      chk8({6'h0, clkDivSel}, 8'h03);
      intIrq <= 8'h00;
      wr(8'hD6, 8'h00);
      wr(8'hE2, 8'h00);
      op(`SIPDC_OP_IDLE);
      @(posedge clk);
      intIrq <= 8'hFF;
      port0ExtIrq <= 8'h00;
      repeat (20) @(posedge clk);
      #1 chk1(cpuClkEn, 1'b0);
      chk1(wakeReq, 1'b0);
      reset_run();
      rdchk(8'hD4, 8'hFF, 8'h00);
      rdchk(8'hD5, 8'hFF, 8'h03);
      finish_test();
   end
endmodule
